// ==== verilog/pdw_params.svh ====
`ifndef PDW_PARAMS_SVH
`define PDW_PARAMS_SVH
// word framing
`define PDW_WORD_W      24
`define PDW_SEL_MSB     3
`define PDW_R0_SEL_BIT  0
`define PDW_R1_SEL      4'h1
// first word fields
`define PDW_N_MSB       23
`define PDW_N_LSB       13
`define PDW_FN_MSB      12
`define PDW_FN_LSB      1
// second word fields
`define PDW_PD_BIT      23
`define PDW_RD_MSB      21
`define PDW_RD_LSB      16
`define PDW_FD_MSB      15
`define PDW_FD_LSB      4
// reset values of the held fields
`define PDW_N_RST       11'h044
`define PDW_FN_RST      12'h000
`define PDW_FD_RST      12'h001
`define PDW_RD_RST      6'h01
`define PDW_PD_RST      1'b1
// prescaler moduli
`define PDW_PRESC_BASE  5'h10
`define PDW_PRESC_SWAL  5'h01
`define PDW_PRESC_SEL   5'h04
// integer count limits per modulator order
`define PDW_N_MIN       11'h042
`define PDW_N_67        11'h043
`define PDW_N_3RD_HI    11'h7f9
`define PDW_N_2ND_HI    11'h7fd
`define PDW_N_MAX       11'h7fe
`define PDW_ORD_2       3'h2
`define PDW_ORD_4       3'h4
`define PDW_ORD_RST     3'h3
// host timing, counted in clk_in cycles
`define PDW_HALF_CYC    4'h4
`define PDW_LOAD_CYC    5'h10
// host register offsets
`define PDW_ADDR_WORD   4'h0
`define PDW_ADDR_ORDER  4'h4
`define PDW_ADDR_STAT   4'h8
`define PDW_STAT_BUSY   0
`define PDW_STAT_REFUSE 1
`endif

// ==== verilog/pdw_pkg.sv ====
`include "pdw_params.svh"
package pdw_pkg;
  typedef logic [`PDW_WORD_W-1:0] pdw_word_type;
  typedef logic [10:0]            pdw_count_type;
  typedef logic [11:0]            pdw_frac_type;
  typedef logic [5:0]             pdw_rdiv_type;
  typedef logic [2:0]             pdw_order_type;

  typedef enum logic [1:0] {
    PDW_IDLE  = 2'b00,
    PDW_SHIFT = 2'b01,
    PDW_LOAD  = 2'b10,
    PDW_GAP   = 2'b11
  } pdw_hstate_type;

  // first word: one select bit only
  function automatic logic pdw_is_w0(input pdw_word_type w);
    pdw_is_w0 = (w[`PDW_R0_SEL_BIT] == 1'b0);
  endfunction

  function automatic logic pdw_is_w1(input pdw_word_type w);
    pdw_is_w1 = (w[`PDW_SEL_MSB:0] == `PDW_R1_SEL);
  endfunction

  // integer count legal for the modulator order
  function automatic logic pdw_count_ok(input pdw_count_type n, input pdw_order_type ord);
    logic in_range;
    logic need_2nd;
    logic bar_4th;
    in_range = (n >= `PDW_N_MIN) && (n <= `PDW_N_MAX);
    need_2nd = (n == `PDW_N_MIN) || (n >= `PDW_N_2ND_HI);
    bar_4th  = (n == `PDW_N_67) || (n >= `PDW_N_3RD_HI);
    pdw_count_ok = in_range && !(need_2nd && ord != `PDW_ORD_2) && !(bar_4th && ord == `PDW_ORD_4);
  endfunction
endpackage : pdw_pkg

// ==== verilog/pdw_link_if.sv ====
`timescale 1ns/1ps
// three-wire programming link
interface pdw_link_if;
  logic link_clk;
  logic link_data;
  logic link_load;

  modport host (output link_clk, output link_data, output link_load);
  modport device (input link_clk, input link_data, input link_load);
endinterface : pdw_link_if

// ==== verilog/pdw_fbdiv.sv ====
`timescale 1ns/1ps
module pdw_fbdiv
  import pdw_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  input  wire logic          run_in,
  input  pdw_pkg::pdw_count_type count_in,
  output logic               fb_pulse_out,
  output logic [1:0]         swallow_out,
  output logic [1:0]         select_out,
  output logic [6:0]         main_out
);
  typedef struct packed {
    logic [4:0] pc;
    logic [6:0] mc;
    logic [1:0] a_left;
    logic [1:0] c_left;
    logic [1:0] a;
    logic [1:0] c;
    logic [6:0] b;
    logic       pulse;
  } pdw_fb_type;

  pdw_fb_type st_r;
  pdw_fb_type st_nxt;
  logic [4:0] modulus;

  // modulus is 16, 17, 20 or 21 by what is left of each count
  always_comb begin
    modulus = `PDW_PRESC_BASE + ((st_r.a_left != 2'h0) ? `PDW_PRESC_SWAL : 5'h00)
            + ((st_r.c_left != 2'h0) ? `PDW_PRESC_SEL : 5'h00);
  end

  // counts split from the binary ratio, new ratio taken while stopped or at a period boundary
  always_comb begin
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    if (!run_in) begin
      st_nxt = '0;
      st_nxt.a = count_in[1:0];
      st_nxt.c = count_in[3:2];
      st_nxt.b = count_in[10:4];
      st_nxt.a_left = count_in[1:0];
      st_nxt.c_left = count_in[3:2];
    end else if (st_r.pc == modulus - 5'h01) begin
      st_nxt.pc = 5'h00;
      if (st_r.a_left != 2'h0) st_nxt.a_left = st_r.a_left - 2'h1;
      if (st_r.c_left != 2'h0) st_nxt.c_left = st_r.c_left - 2'h1;
      if (st_r.mc >= st_r.b - 7'h01) begin
        st_nxt.pulse  = 1'b1;
        st_nxt.mc     = 7'h00;
        st_nxt.a      = count_in[1:0];
        st_nxt.c      = count_in[3:2];
        st_nxt.b      = count_in[10:4];
        st_nxt.a_left = count_in[1:0];
        st_nxt.c_left = count_in[3:2];
      end else begin
        st_nxt.mc = st_r.mc + 7'h01;
      end
    end else begin
      st_nxt.pc = st_r.pc + 5'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign fb_pulse_out = st_r.pulse;
  assign swallow_out  = st_r.a;
  assign select_out   = st_r.c;
  assign main_out     = st_r.b;
endmodule : pdw_fbdiv

// ==== verilog/pdw_device.sv ====
// Operation
// - first word picked by one zero bit
// - 24-bit words, low four bits select
// - feedback prescaler 16/17/20/21 with counters
// - host writes count as plain binary
// - count 66 only with second order
// - count 67 only second or third
// - first word holds 12-bit fractional numerator
// - second word holds 12-bit denominator
// - reference divide codes 1 to 63
// - power-down bit, enable and auto-up precedence
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pdw_device
  import pdw_pkg::*;
(
  pdw_link_if.device                link,
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  input  wire logic                 enable_in,
  input  wire logic [1:0]           auto_power_up_setting_in,
  output pdw_pkg::pdw_count_type    rf_feedback_count_out,
  output pdw_pkg::pdw_frac_type     rf_frac_numerator_out,
  output pdw_pkg::pdw_frac_type     rf_frac_denominator_out,
  output pdw_pkg::pdw_rdiv_type     rf_ref_divide_out,
  output logic                      rf_power_down_out,
  output logic                      rf_active_out,
  output logic                      cp_drive_enable_out,
  output logic                      ref_pulse_out,
  output logic                      fb_pulse_out,
  output logic [1:0]                rf_swallow_count_out,
  output logic [1:0]                rf_prescaler_select_count_out,
  output logic [6:0]                rf_main_count_out,
  output logic                      word_taken_out
);
  // link side state, clocked by the link clock
  typedef struct packed {
    pdw_word_type sh;
  } pdw_lnk_type;

  // core side state
  typedef struct packed {
    logic [2:0]    load_sync;
    pdw_word_type  word_s1;
    pdw_word_type  word_s2;
    logic [1:0]    en_sync;
    logic [1:0]    auto_power_up_setting_s1;
    logic [1:0]    auto_power_up_setting_s2;
    pdw_count_type n;
    pdw_frac_type  fn;
    pdw_frac_type  fd;
    pdw_rdiv_type  rd;
    logic          pd;
    logic          active;
    logic          cp_en;
    pdw_rdiv_type  rcnt;
    logic          ref_pulse;
    logic          taken;
  } pdw_dev_type;

  pdw_lnk_type lnk_r;
  pdw_lnk_type lnk_nxt;
  pdw_dev_type st_r;
  pdw_dev_type st_nxt;
  logic        load_rise;
  logic        fb_run;
  logic        fb_pulse;
  logic [1:0]  fb_swal;
  logic [1:0]  fb_sel;
  logic [6:0]  fb_main;

  // shift in msb first while the load strobe is low
  always_comb begin
    lnk_nxt = lnk_r;
    if (!link.link_load) begin
      lnk_nxt.sh = {lnk_r.sh[`PDW_WORD_W-2:0], link.link_data};
    end
  end

  // the link clock stops outside frames, so nothing here waits on it
  always_ff @(posedge link.link_clk or negedge rstn_in) begin
    if (!rstn_in) lnk_r <= '0;
    else lnk_r <= lnk_nxt;
  end

  // load edge seen only after its second flop
  assign load_rise = st_r.load_sync[1] & ~st_r.load_sync[2];

  // core side: crossing, word decode, power and reference divider
  always_comb begin
    st_nxt = st_r;
    st_nxt.taken = 1'b0;
    // two flops on the enable and auto-up pins and on the held word, three on the load pin;
    // the word is still when the strobe rises, so the copy is clean
    st_nxt.load_sync = {st_r.load_sync[1:0], link.link_load};
    st_nxt.word_s1   = lnk_r.sh;
    st_nxt.word_s2   = st_r.word_s1;
    st_nxt.en_sync   = {st_r.en_sync[0], enable_in};
    st_nxt.auto_power_up_setting_s1   = auto_power_up_setting_in;
    st_nxt.auto_power_up_setting_s2   = st_r.auto_power_up_setting_s1;

    if (load_rise) begin
      if (pdw_is_w0(st_r.word_s2)) begin
        st_nxt.n     = st_r.word_s2[`PDW_N_MSB:`PDW_N_LSB];
        st_nxt.fn    = st_r.word_s2[`PDW_FN_MSB:`PDW_FN_LSB];
        st_nxt.taken = 1'b1;
      end else if (pdw_is_w1(st_r.word_s2)) begin
        st_nxt.pd    = st_r.word_s2[`PDW_PD_BIT];
        st_nxt.rd    = st_r.word_s2[`PDW_RD_MSB:`PDW_RD_LSB];
        st_nxt.fd    = st_r.word_s2[`PDW_FD_MSB:`PDW_FD_LSB];
        st_nxt.taken = 1'b1;
      end
      // other selects belong to blocks not built here
    end

    // enable low wins, then auto power-up, then the power-down bit
    if (!st_r.en_sync[1]) begin
      st_nxt.active = 1'b0;
    end else if (st_r.auto_power_up_setting_s2 != 2'h0) begin
      st_nxt.active = 1'b1;
    end else begin
      st_nxt.active = ~st_r.pd;
    end
    st_nxt.cp_en = st_nxt.active;

    // reference divider: code k divides by k; code 0 stalls
    st_nxt.ref_pulse = 1'b0;
    if (!st_r.active || st_r.rd == 6'h00) begin
      st_nxt.rcnt = 6'h00;
    end else if (st_r.rcnt >= st_r.rd - 6'h01) begin
      st_nxt.rcnt      = 6'h00;
      st_nxt.ref_pulse = 1'b1;
    end else begin
      st_nxt.rcnt = st_r.rcnt + 6'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r    <= '0;
      st_r.n  <= `PDW_N_RST;
      st_r.fn <= `PDW_FN_RST;
      st_r.fd <= `PDW_FD_RST;
      st_r.rd <= `PDW_RD_RST;
      st_r.pd <= `PDW_PD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // feedback divider runs only while powered
  assign fb_run = st_r.active;

  pdw_fbdiv u_fbdiv (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .run_in       (fb_run),
    .count_in     (st_r.n),
    .fb_pulse_out (fb_pulse),
    .swallow_out  (fb_swal),
    .select_out   (fb_sel),
    .main_out     (fb_main)
  );

  // outputs straight from flops
  assign rf_feedback_count_out         = st_r.n;
  assign rf_frac_numerator_out         = st_r.fn;
  assign rf_frac_denominator_out       = st_r.fd;
  assign rf_ref_divide_out             = st_r.rd;
  assign rf_power_down_out             = st_r.pd;
  assign rf_active_out                 = st_r.active;
  assign cp_drive_enable_out           = st_r.cp_en;
  assign ref_pulse_out                 = st_r.ref_pulse;
  assign word_taken_out                = st_r.taken;
  assign fb_pulse_out                  = fb_pulse;
  assign rf_swallow_count_out          = fb_swal;
  assign rf_prescaler_select_count_out = fb_sel;
  assign rf_main_count_out             = fb_main;
endmodule : pdw_device

// ==== verilog/pdw_host.sv ====
`timescale 1ns/1ps
module pdw_host
  import pdw_pkg::*;
(
  pdw_link_if.host             link,
  input  wire logic            clk_in,
  input  wire logic            rstn_in,
  input  wire logic [3:0]      addr_in,
  input  wire logic [31:0]     wdata_in,
  input  wire logic            wr_in,
  input  wire logic            rd_in,
  output logic [31:0]          rdata_out
);
  typedef struct packed {
    pdw_hstate_type state;
    logic [3:0]     div;
    logic [4:0]     bits;
    logic [4:0]     lcnt;
    pdw_word_type   sh;
    logic           sclk;
    logic           data;
    logic           load;
    logic           refused;
    pdw_order_type  order;
    logic [31:0]    rdata;
  } pdw_host_type;

  pdw_host_type st_r;
  pdw_host_type st_nxt;
  logic         half;
  logic         busy;
  pdw_word_type wword;

  assign busy  = (st_r.state != PDW_IDLE);
  assign half  = (st_r.div == `PDW_HALF_CYC - 4'h1);
  assign wword = wdata_in[`PDW_WORD_W-1:0];

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 32'h0000_0000;
    st_nxt.div   = (busy && !half) ? st_r.div + 4'h1 : 4'h0;

    // software port; a refusal set in the same cycle beats the clear
    if (wr_in && addr_in == `PDW_ADDR_STAT && wdata_in[`PDW_STAT_REFUSE]) st_nxt.refused = 1'b0;
    if (wr_in && addr_in == `PDW_ADDR_ORDER) st_nxt.order = wdata_in[2:0];
    if (wr_in && addr_in == `PDW_ADDR_WORD) begin
      if (busy || (pdw_is_w0(wword) && !pdw_count_ok(wword[`PDW_N_MSB:`PDW_N_LSB], st_r.order))) begin
        st_nxt.refused = 1'b1;
      end else begin
        st_nxt.state = PDW_SHIFT;
        st_nxt.sh    = wword;
        st_nxt.data  = wword[`PDW_WORD_W-1];
        st_nxt.bits  = 5'h00;
        st_nxt.div   = 4'h0;
      end
    end
    if (rd_in) begin
      case (addr_in)
        `PDW_ADDR_ORDER: st_nxt.rdata = {29'h0, st_r.order};
        `PDW_ADDR_STAT:  st_nxt.rdata = {30'h0, st_r.refused, busy};
        default:         st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // link sequencer: data changes on the falling edge, device samples rising
    case (st_r.state)
      PDW_IDLE: begin
        st_nxt.sclk = 1'b0;
        st_nxt.load = 1'b0;
      end
      PDW_SHIFT: begin
        if (half) begin
          st_nxt.sclk = ~st_r.sclk;
          if (st_r.sclk) begin
            if (st_r.bits == 5'(`PDW_WORD_W - 1)) begin
              st_nxt.state = PDW_LOAD;
              st_nxt.load  = 1'b1;
              st_nxt.lcnt  = 5'h00;
            end else begin
              st_nxt.bits = st_r.bits + 5'h01;
              st_nxt.sh   = {st_r.sh[`PDW_WORD_W-2:0], 1'b0};
              st_nxt.data = st_r.sh[`PDW_WORD_W-2];
            end
          end
        end
      end
      PDW_LOAD: begin
        // strobe held long enough for a two-flop crossing on the far side
        st_nxt.lcnt = st_r.lcnt + 5'h01;
        if (st_r.lcnt == `PDW_LOAD_CYC - 5'h01) begin
          st_nxt.load  = 1'b0;
          st_nxt.state = PDW_GAP;
        end
      end
      PDW_GAP: begin
        if (half) st_nxt.state = PDW_IDLE;
      end
      default: st_nxt.state = PDW_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r       <= '0;
      st_r.order <= `PDW_ORD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.link_clk  = st_r.sclk;
  assign link.link_data = st_r.data;
  assign link.link_load = st_r.load;
  assign rdata_out      = st_r.rdata;
endmodule : pdw_host

// ==== testbench/pdw_link_chk.sv ====
`timescale 1ns/1ps
// watches the programming link on the host clock
module pdw_link_chk (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_load
);
  logic        clk_d_r;
  logic        load_d_r;
  logic [4:0]  bits_r;
  logic [23:0] sh_r;
  wire         rise  = link_clk & ~clk_d_r;
  wire         ld_up = link_load & ~load_d_r;
  // rebuild each word as the device shifts it in
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_d_r <= 1'b0;
      load_d_r <= 1'b0;
      bits_r <= 5'h00;
      sh_r <= 24'h000000;
    end else begin
      clk_d_r <= link_clk;
      load_d_r <= link_load;
      if (ld_up) bits_r <= 5'h00;
      else if (rise) bits_r <= bits_r + 5'h01;
      if (rise) sh_r <= {sh_r[22:0], link_data};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_load_hold;
    link_load [*8] ##1 link_load [*8] ##1 !link_load;
  endsequence
  sequence s_clk_high;
    link_clk [*4] ##1 !link_clk;
  endsequence
  AST_LOAD_LEN: assert property ($rose(link_load) |-> s_load_hold)
    else $error("load strobe length wrong");
  AST_CLK_HIGH: assert property ($rose(link_clk) |-> s_clk_high)
    else $error("link clock high phase wrong");
  AST_CLK_LOW: assert property ($fell(link_clk) |-> !link_clk [*4])
    else $error("link clock low phase short");
  AST_GAP: assert property ($fell(link_load) |-> !link_clk [*4])
    else $error("no gap after load");
  AST_IDLE: assert property (link_load |-> !link_clk)
    else $error("link clock runs during load");
  AST_STABLE: assert property (link_clk |-> $stable(link_data))
    else $error("data moved while clock high");
  AST_BITS: assert property (ld_up |-> bits_r == 5'h18)
    else $error("word is not 24 bits");
  AST_W0_N: assert property (ld_up && !sh_r[0] |-> sh_r[23:13] >= 11'h042 && sh_r[23:13] <= 11'h7fe)
    else $error("illegal count on link");
endmodule // pdw_link_chk

// ==== testbench/pll_divider_word_registers_tb.sv ====
`timescale 1ns/1ps
`include "pdw_params.svh"
module pll_divider_word_registers_tb;
  import pdw_pkg::*;
  logic clk_in = 1'b0, rstn_in = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b1;
  logic [1:0] auto_power_up_setting = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  pdw_count_type n_o, n_exp;
  pdw_frac_type fn_o, fd_o;
  pdw_rdiv_type r_o;
  logic pd_o, act_o, cp_o, fb_o, ref_o, tk_o;
  int taken_n = 0;
  logic [1:0] sw_o, sel_o;
  logic [6:0] mn_o;
  int mismatches = 0, checks = 0, cyc;
  pdw_link_if link_if ();
  always #2 clk_in = ~clk_in;
  pdw_host u_pdw_host (.link(link_if), .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
  pdw_device u_pdw_device (.link(link_if), .clk_in(clk_in), .rstn_in(rstn_in), .enable_in(en),
    .auto_power_up_setting_in(auto_power_up_setting), .rf_feedback_count_out(n_o), .rf_frac_numerator_out(fn_o),
    .rf_frac_denominator_out(fd_o), .rf_ref_divide_out(r_o), .rf_power_down_out(pd_o),
    .rf_active_out(act_o), .cp_drive_enable_out(cp_o), .ref_pulse_out(ref_o), .fb_pulse_out(fb_o),
    .rf_swallow_count_out(sw_o), .rf_prescaler_select_count_out(sel_o), .rf_main_count_out(mn_o),
    .word_taken_out(tk_o));
  // count accepted words so ignored selects can be told apart
  always @(posedge clk_in) if (tk_o === 1'b1) taken_n++;
  pdw_link_chk u_pdw_link_chk (.clk_in(clk_in), .rstn_in(rstn_in), .link_clk(link_if.link_clk),
    .link_data(link_if.link_data), .link_load(link_if.link_load));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // poll busy under a bound; a refused word never sets it
  task automatic send(input logic [23:0] w);
    bus_wr(`PDW_ADDR_WORD, {8'h00, w});
    repeat (2) @(posedge clk_in);
    for (int i = 0; i < 500; i++) begin
      bus_rd(`PDW_ADDR_STAT, d);
      if (d[`PDW_STAT_BUSY] === 1'b0) break;
    end
    repeat (4) @(posedge clk_in);
  endtask
  function automatic logic [23:0] w0(input logic [10:0] n, input logic [11:0] fn);
    return {n, fn, 1'b0};
  endfunction
  function automatic logic [23:0] w1(input logic pd, input logic [5:0] r, input logic [11:0] fd);
    return {pd, 1'b0, r, fd, 4'h1};
  endfunction
  // legality table: order, count, accepted
  logic [2:0] t_ord [8] = '{3'h3, 3'h2, 3'h4, 3'h3, 3'h2, 3'h2, 3'h2, 3'h4};
  logic [10:0] t_n [8] = '{11'h042, 11'h042, 11'h043, 11'h043, 11'h041, 11'h7ff, 11'h7fe, 11'h7fc};
  logic t_ok [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  // power precedence table: enable, auto setting, expected active
  logic p_en [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic [1:0] p_at [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic p_act [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  // caps the run at 60000 clocks; a hung handshake still ends send after 500 polls
  initial begin
    repeat (60000) @(posedge clk_in);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk("n_rst", `PDW_N_RST, n_o);
    chk("fd_rst", `PDW_FD_RST, fd_o);
    chk("fn_rst", `PDW_FN_RST, fn_o);
    chk("r_rst", `PDW_RD_RST, r_o);
    chk("pd_rst", `PDW_PD_RST, pd_o);
    send(w0(11'h044, 12'habc));
    chk("n", 11'h044, n_o);
    chk("fn", 12'habc, fn_o);
    chk("swallow", 2'h0, sw_o);
    chk("presel", 2'h1, sel_o);
    chk("main", 7'h04, mn_o);
    chk("taken_w0", 32'd1, taken_n);
    // power up first: the feedback divider only runs while active
    send(w1(1'b0, 6'h3f, 12'h123));
    chk("fd", 12'h123, fd_o);
    chk("rdiv", 6'h3f, r_o);
    chk("pd", 1'b0, pd_o);
    chk("active", 1'b1, act_o);
    chk("taken_w1", 32'd2, taken_n);
    // second full feedback period after the new count
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      for (int i = 0; i < 3000 && fb_o !== 1'b1; i++) @(posedge clk_in);
    end
    cyc = 0;
    do begin
      @(posedge clk_in);
      cyc++;
    end while (fb_o !== 1'b1 && cyc < 3000);
    chk("fb_period", 32'd68, cyc);
    // reference divider period for code 63
    for (int i = 0; i < 3000 && ref_o !== 1'b1; i++) @(posedge clk_in);
    cyc = 0;
    do begin
      @(posedge clk_in);
      cyc++;
    end while (ref_o !== 1'b1 && cyc < 3000);
    chk("ref_period", 32'd63, cyc);
    send(24'h000003);
    chk("taken_none", 32'd2, taken_n);
    chk("fd_keep", 12'h123, fd_o);
    chk("n_keep", 11'h044, n_o);
    n_exp = 11'h044;
    for (int i = 0; i < 8; i++) begin
      bus_wr(`PDW_ADDR_ORDER, {29'h0, t_ord[i]});
      bus_wr(`PDW_ADDR_STAT, 32'h2);
      bus_rd(`PDW_ADDR_ORDER, d);
      chk("order", t_ord[i], d[2:0]);
      send(w0(t_n[i], 12'h001));
      if (t_ok[i]) n_exp = t_n[i];
      bus_rd(`PDW_ADDR_STAT, d);
      chk("refused", !t_ok[i], d[`PDW_STAT_REFUSE]);
      chk("n_after", n_exp, n_o);
    end
    send(w1(1'b1, 6'h01, 12'h001));
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      en <= p_en[i];
      auto_power_up_setting <= p_at[i];
      repeat (8) @(posedge clk_in);
      chk("pwr_active", p_act[i], act_o);
      chk("pwr_pump", p_act[i], cp_o);
    end
    final_report();
  end
endmodule // pll_divider_word_registers_tb
